/* pfw_ctrl.sv */
// Purpose: host controller that reads and page-programs a parallel flash
// Assumes: user fills the page buffer before asking for a program
// Notes:   end of program is found by poll bit and toggle bit agreeing
`timescale 1ns/1ps
module pfw_ctrl
	import pfw_pkg::*;
#(
	parameter int                        PWRUP_LIMIT = pfw_pkg::PWRUP_CYC,
	parameter int                        WC_LIMIT    = pfw_pkg::WC_CYC,
	parameter logic [pfw_pkg::ADDR_W-1:0] LOCK_ADDR0 = 15'h0001,
	parameter logic [pfw_pkg::ADDR_W-1:0] LOCK_ADDR1 = 15'h0002,
	parameter logic [pfw_pkg::ADDR_W-1:0] LOCK_ADDR2 = 15'h0003,
	parameter logic [pfw_pkg::DATA_W-1:0] LOCK_DATA0 = 8'h01,
	parameter logic [pfw_pkg::DATA_W-1:0] LOCK_DATA1 = 8'h02,
	parameter logic [pfw_pkg::DATA_W-1:0] LOCK_DATA2 = 8'h03
) (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        reset_n,
	// command
	input  wire logic                        cmd_valid,
	input  wire logic                        cmd_write,
	input  wire logic [pfw_pkg::PAGE_W-1:0]  cmd_page,
	input  wire logic [pfw_pkg::IDX_W-1:0]   cmd_byte,
	input  wire logic                        lock_prefix_en,
	output logic                             cmd_ready,
	output logic [pfw_pkg::DATA_W-1:0]       rd_data,
	output logic                             rd_valid,
	output logic                             prog_done,
	output logic                             prog_fail,
	// page buffer fill
	input  wire logic                        buf_wr_en,
	input  wire logic [pfw_pkg::IDX_W-1:0]   buf_wr_idx,
	input  wire logic [pfw_pkg::DATA_W-1:0]  buf_wr_data,
	// flash pins
	output logic                             flash_ce_n,
	output logic                             flash_oe_n,
	output logic                             flash_we_n,
	output logic [pfw_pkg::PAGE_W-1:0]       page_select_addr,
	output logic [pfw_pkg::IDX_W-1:0]        byte_in_page_addr,
	input  wire logic [pfw_pkg::DATA_W-1:0]  flash_dq_i,
	output logic [pfw_pkg::DATA_W-1:0]       flash_dq_o,
	output logic                             flash_dq_oe_n
);
	import pfw_pkg::*;
	default clocking cb_chk @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	localparam int TOTAL_MAX = PAGE_BYTES + PREFIX_LEN;
	localparam logic [6:0] LAST_PLAIN = 7'(PAGE_BYTES - 1);
	localparam logic [6:0] LAST_PRE   = 7'(TOTAL_MAX - 1);
	pfw_state_t st_r, st_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic [WC_W-1:0]   wc_r, wc_nxt;
	logic [6:0]        step_r, step_nxt;
	logic [PAGE_W-1:0] pg_r, pg_nxt, pa_r, pa_nxt;
	logic [IDX_W-1:0]  by_r, by_nxt, ba_r, ba_nxt;
	logic              pre_r, pre_nxt, ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt;
	logic [DATA_W-1:0] dq_r, dq_nxt, rdd_r, rdd_nxt;
	logic              doe_r, doe_nxt, rdv_r, rdv_nxt, done_r, done_nxt;
	logic              fail_r, fail_nxt, rdy_r, rdy_nxt;
	logic              exp7_r, exp7_nxt, prev6_r, prev6_nxt, pok_r, pok_nxt;
	logic [DATA_W-1:0] s1_r, s2_r, s3_r, dqs_r;
	wire               in_pre   = pre_r && (step_r < 7'(PREFIX_LEN));
	wire [6:0]         pstep    = pre_r ? step_r - 7'(PREFIX_LEN) : step_r;
	wire [IDX_W-1:0]   pidx     = pstep[IDX_W-1:0];
	wire [DATA_W-1:0]  buf_q;
	wire [ADDR_W-1:0]  pre_addr = (step_r == 7'h00) ? LOCK_ADDR0 :
	                              (step_r == 7'h01) ? LOCK_ADDR1 : LOCK_ADDR2;
	wire [DATA_W-1:0]  pre_data = (step_r == 7'h00) ? LOCK_DATA0 :
	                              (step_r == 7'h01) ? LOCK_DATA1 : LOCK_DATA2;
	// prefix loads share the page load path, so their timing is identical
	wire [ADDR_W-1:0]  ld_addr  = in_pre ? pre_addr : {pg_r, pidx};
	wire [DATA_W-1:0]  ld_data  = in_pre ? pre_data : buf_q;
	wire               last     = step_r == (pre_r ? LAST_PRE : LAST_PLAIN);
	wire               cnt_zero = cnt_r == '0;
	wire               is_done  = (dqs_r[POLL_BIT] == exp7_r) && pok_r
	                              && (dqs_r[TOGGLE_BIT] == prev6_r);
	wire               wc_over  = wc_r >= WC_W'(WC_LIMIT);
	pfw_page_ram #(.W(DATA_W), .D(PAGE_BYTES), .A(IDX_W)) u_ram (
		.sys_clk (sys_clk),
		.wr_en   (buf_wr_en),
		.wr_addr (buf_wr_idx),
		.wr_data (buf_wr_data),
		.rd_addr (pidx),
		.rd_data (buf_q)
	);
	always_comb begin
		st_nxt = st_r;  cnt_nxt = cnt_zero ? cnt_r : cnt_r - 1'b1;
		wc_nxt = wc_r;  step_nxt = step_r;  pg_nxt = pg_r;  by_nxt = by_r;
		pa_nxt = pa_r;  ba_nxt = ba_r;  pre_nxt = pre_r;
		ce_nxt = ce_r;  oe_nxt = oe_r;  we_nxt = we_r;  dq_nxt = dq_r;
		doe_nxt = doe_r;  rdd_nxt = rdd_r;  rdv_nxt = 1'b0;
		done_nxt = 1'b0;  fail_nxt = 1'b0;  rdy_nxt = rdy_r;
		exp7_nxt = exp7_r;  prev6_nxt = prev6_r;  pok_nxt = pok_r;
		unique case (st_r)
			PFW_PWR: begin
				if (cnt_zero) begin
					st_nxt = PFW_IDLE;
					rdy_nxt = 1'b1;
				end
			end
			PFW_IDLE: begin
				if (cmd_valid) begin
					rdy_nxt = 1'b0;
					pg_nxt = cmd_page;
					by_nxt = cmd_byte;
					pre_nxt = lock_prefix_en;
					step_nxt = '0;
					if (cmd_write) begin
						st_nxt = PFW_WSET;
						cnt_nxt = CNT_W'(1);
						doe_nxt = 1'b0;
					end else begin
						st_nxt = PFW_RD;
						pa_nxt = cmd_page;
						ba_nxt = cmd_byte;
						ce_nxt = 1'b0;
						oe_nxt = 1'b0;
						cnt_nxt = CNT_W'(RD_WAIT);
					end
				end
			end
			PFW_WSET: begin
				pa_nxt = ld_addr[ADDR_W-1:IDX_W];
				ba_nxt = ld_addr[IDX_W-1:0];
				if (cnt_zero) begin
					dq_nxt = ld_data;
					st_nxt = PFW_WLOW;
					ce_nxt = 1'b0;
					we_nxt = 1'b0;
					cnt_nxt = CNT_W'(WE_LOW_CYC - 1);
				end
			end
			PFW_WLOW: begin
				if (cnt_zero) begin
					we_nxt = 1'b1;
					ce_nxt = 1'b1;
					st_nxt = PFW_WHI;
					if (last) begin
						exp7_nxt = dq_r[POLL_BIT];
					end
				end
			end
			PFW_WHI: begin
				if (last) begin
					doe_nxt = 1'b1;
					st_nxt = PFW_TMO;
					cnt_nxt = CNT_W'(LOAD_TMO_CYC);
					wc_nxt = '0;
				end else begin
					step_nxt = step_r + 1'b1;
					st_nxt = PFW_WSET;
					cnt_nxt = CNT_W'(1);
				end
			end
			PFW_TMO: begin
				// the write time limit starts at the first poll, not in the load timeout
				if (cnt_zero) begin
					st_nxt = PFW_PRD;
					pa_nxt = pg_r;
					ba_nxt = IDX_W'(PAGE_BYTES - 1);
					ce_nxt = 1'b0;
					oe_nxt = 1'b0;
					pok_nxt = 1'b0;
					cnt_nxt = CNT_W'(RD_WAIT);
				end
			end
			PFW_PRD: begin
				wc_nxt = wc_r + 1'b1;
				if (cnt_zero) begin
					ce_nxt = 1'b1;
					oe_nxt = 1'b1;
					prev6_nxt = dqs_r[TOGGLE_BIT];
					pok_nxt = 1'b1;
					if (is_done) begin
						st_nxt = PFW_IDLE;
						done_nxt = 1'b1;
						rdy_nxt = 1'b1;
					end else if (wc_over) begin
						st_nxt = PFW_IDLE;
						fail_nxt = 1'b1;
						rdy_nxt = 1'b1;
					end else begin
						st_nxt = PFW_PGAP;
						cnt_nxt = CNT_W'(1);
					end
				end
			end
			PFW_PGAP: begin
				// the gap gives the toggle bit a fresh read edge each time
				wc_nxt = wc_r + 1'b1;
				if (cnt_zero) begin
					st_nxt = PFW_PRD;
					ce_nxt = 1'b0;
					oe_nxt = 1'b0;
					cnt_nxt = CNT_W'(RD_WAIT);
				end
			end
			PFW_RD: begin
				if (cnt_zero) begin
					rdd_nxt = dqs_r;
					rdv_nxt = 1'b1;
					ce_nxt = 1'b1;
					oe_nxt = 1'b1;
					st_nxt = PFW_IDLE;
					rdy_nxt = 1'b1;
				end
			end
			default: st_nxt = PFW_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= PFW_PWR;  cnt_r <= CNT_W'(PWRUP_LIMIT - 1);  wc_r <= '0;
			step_r <= '0;  pg_r <= '0;  by_r <= '0;  pa_r <= '0;  ba_r <= '0;
			pre_r <= 1'b0;  ce_r <= 1'b1;  oe_r <= 1'b1;  we_r <= 1'b1;
			dq_r <= '0;  doe_r <= 1'b1;  rdd_r <= '0;  rdv_r <= 1'b0;
			done_r <= 1'b0;  fail_r <= 1'b0;  rdy_r <= 1'b0;
			exp7_r <= 1'b0;  prev6_r <= 1'b0;  pok_r <= 1'b0;
		end else begin
			st_r <= st_nxt;  cnt_r <= cnt_nxt;  wc_r <= wc_nxt;
			step_r <= step_nxt;  pg_r <= pg_nxt;  by_r <= by_nxt;
			pa_r <= pa_nxt;  ba_r <= ba_nxt;  pre_r <= pre_nxt;
			ce_r <= ce_nxt;  oe_r <= oe_nxt;  we_r <= we_nxt;
			dq_r <= dq_nxt;  doe_r <= doe_nxt;  rdd_r <= rdd_nxt;  rdv_r <= rdv_nxt;
			done_r <= done_nxt;  fail_r <= fail_nxt;  rdy_r <= rdy_nxt;
			exp7_r <= exp7_nxt;  prev6_r <= prev6_nxt;  pok_r <= pok_nxt;
		end
	end
	// pin data: a value counts once stages two and three agree
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_r <= '0;  s2_r <= '0;  s3_r <= '0;  dqs_r <= '0;
		end else begin
			s1_r <= flash_dq_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				dqs_r <= s3_r;
			end
		end
	end
	assign cmd_ready = rdy_r;  assign rd_data = rdd_r;  assign rd_valid = rdv_r;
	assign prog_done = done_r;  assign prog_fail = fail_r;
	assign flash_ce_n = ce_r;  assign flash_oe_n = oe_r;  assign flash_we_n = we_r;
	assign page_select_addr = pa_r;  assign byte_in_page_addr = ba_r;
	assign flash_dq_o = dq_r;  assign flash_dq_oe_n = doe_r;

	// helper counters watched only by the checks below
	logic [CNT_W-1:0] gap_r;
	logic [6:0]       nld_r;
	logic [WC_W-1:0]  up_r;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_r <= '0;  nld_r <= '0;  up_r <= '0;
		end else begin
			gap_r <= !we_r ? '0 : gap_r + 1'b1;
			nld_r <= (st_r == PFW_IDLE) ? '0 : nld_r + 7'((we_r && !we_nxt) ? 1 : 0);
			up_r <= (up_r == '1) ? up_r : up_r + 1'b1;
		end
	end
	wire fell_we = we_r && !we_nxt;
	int unsigned gap_lim = LOAD_TMO_CYC;

	property p_load_pins;
		!flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n;
	endproperty
	a_load_pins: assert property (p_load_pins) else $error("load pins wrong");
	property p_no_fight;
		!flash_oe_n |-> flash_dq_oe_n;
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("bus contention");
	property p_gap;
		(fell_we && nld_r != 7'h00) |-> (gap_r < gap_lim);
	endproperty
	a_gap: assert property (p_gap) else $error("load gap too long");
	property p_page_hold;
		(fell_we && !in_pre) |=> (page_select_addr == pg_r);
	endproperty
	a_page_hold: assert property (p_page_hold) else $error("page moved");
	property p_full_page;
		$rose(st_r == PFW_TMO) |-> nld_r == (pre_r ? 7'(TOTAL_MAX) : 7'(PAGE_BYTES));
	endproperty
	a_full_page: assert property (p_full_page) else $error("short page");
	property p_prefix;
		(fell_we && pre_r && nld_r == 7'h00) |=>
			({page_select_addr, byte_in_page_addr} == LOCK_ADDR0) && (flash_dq_o == LOCK_DATA0);
	endproperty
	a_prefix: assert property (p_prefix) else $error("prefix missing");
	property p_width;
		$fell(flash_we_n) |-> (!flash_we_n)[*2];
	endproperty
	a_width: assert property (p_width) else $error("strobe too short");
	property p_pwr;
		$fell(flash_we_n) |-> up_r >= WC_W'(PWRUP_LIMIT);
	endproperty
	a_pwr: assert property (p_pwr) else $error("load before power delay");
	property p_read;
		(st_r == PFW_IDLE && cmd_valid && !cmd_write) |-> ##[1:12] rd_valid;
	endproperty
	a_read: assert property (p_read) else $error("read never answered");
endmodule : pfw_ctrl

/* pfw_ctrl_tb_top.sv */
// Purpose: self-checking bench for the page write controller against a flash model
// Assumes: power-up and write limits shortened through parameters
// Notes:   results are queued by the driver and matched by a monitor
`timescale 1ns/1ps
module pfw_ctrl_tb_top;
	import pfw_pkg::*;
	logic              sys_clk = 1'b0;
	logic              reset_n = 1'b0;
	logic              cmd_valid = 1'b0, cmd_write = 1'b0, lock_prefix_en = 1'b0;
	logic              buf_wr_en = 1'b0;
	logic [PAGE_W-1:0] cmd_page = '0;
	logic [IDX_W-1:0]  cmd_byte = '0, buf_wr_idx = '0;
	logic [DATA_W-1:0] buf_wr_data = '0, bus_last = '0, img [0:63];
	logic [DATA_W-1:0] bus;
	wire               cmd_ready, rd_valid, prog_done, prog_fail, dev_en, lock_on, page_viol;
	wire               flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n;
	wire [DATA_W-1:0]  rd_data, flash_dq_o, dev_dq;
	wire [PAGE_W-1:0]  page_select_addr;
	wire [IDX_W-1:0]   byte_in_page_addr;
	logic [9:0]        exp_q [$];
	int                error_cnt = 0, num_checks = 0;

	always #20 sys_clk = ~sys_clk;
	// a released bus flips every cycle, showing the inverse of the value sampled at the last clock edge
	assign bus = dev_en ? dev_dq : (!flash_dq_oe_n ? flash_dq_o : ~bus_last);
	always @(posedge sys_clk) bus_last <= bus;

	pfw_ctrl #(.PWRUP_LIMIT(20), .WC_LIMIT(2000)) i_dut (.sys_clk, .reset_n, .cmd_valid,
		.cmd_write, .cmd_page, .cmd_byte, .lock_prefix_en, .cmd_ready, .rd_data, .rd_valid,
		.prog_done, .prog_fail, .buf_wr_en, .buf_wr_idx, .buf_wr_data, .flash_ce_n,
		.flash_oe_n, .flash_we_n, .page_select_addr, .byte_in_page_addr, .flash_dq_i(bus),
		.flash_dq_o, .flash_dq_oe_n);
	pfw_flash_model i_flash (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
		.addr({page_select_addr, byte_in_page_addr}), .dq_in(bus), .dq_out(dev_dq),
		.dq_en(dev_en), .lock_on, .page_viol);

	function automatic logic [7:0] init_v(input logic [14:0] a);
		return a[7:0] ^ {1'b0, a[14:8]};
	endfunction : init_v

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	// results: read {2'b00,data}, done {2'b01,0}, fail {2'b10,0}
	// sampled mid-cycle, where the one-cycle pulses have settled
	always @(negedge sys_clk) begin
		if (rd_valid || prog_done || prog_fail) begin
			if (exp_q.size() == 0) chk(10'h3ff, 10'h000);
			else chk({prog_fail, prog_done, rd_valid ? rd_data : 8'h00}, exp_q.pop_front());
		end
	end

	task automatic wait_idle();
		int n;
		n = 0;
		while ((exp_q.size() != 0 || cmd_ready !== 1'b1) && n < 20000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 20000) begin
			chk(10'h3ff, 10'h000);
			close_out();
		end
	endtask : wait_idle

	task automatic issue(input logic wr, input logic pre, input logic [8:0] pg,
		input logic [5:0] bi, input logic [9:0] exp);
		wait_idle();
		exp_q.push_back(exp);
		{cmd_valid, cmd_write, lock_prefix_en, cmd_page, cmd_byte} = {1'b1, wr, pre, pg, bi};
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		wait_idle();
	endtask : issue

	task automatic prog(input logic pre, input logic [8:0] pg, input logic [9:0] exp);
		for (int i = 0; i < 64; i++) begin
			@(negedge sys_clk);
			{buf_wr_en, buf_wr_idx, buf_wr_data} = {1'b1, 6'(i), img[i]};
		end
		@(negedge sys_clk);
		buf_wr_en = 1'b0;
		issue(1'b1, pre, pg, 6'h00, exp);
	endtask : prog

	task automatic new_img();
		for (int i = 0; i < 64; i++) img[i] = 8'($urandom);
	endtask : new_img

	initial begin
		logic [8:0] pg;
		logic [5:0] bi;
		void'($urandom(32'h997d));
		repeat (12) @(negedge sys_clk);
		reset_n = 1'b1;
		for (int k = 0; k < 4; k++) begin
			{pg, bi} = 15'($urandom);
			issue(1'b0, 1'b0, pg, bi, {2'b00, init_v({pg, bi})});
		end
		$display("test read done");
		chk({9'h0, lock_on}, 10'h000);
		pg = 9'($urandom);
		new_img();
		prog(1'b0, pg, 10'h100);
		for (int k = 0; k < 64; k += 21) issue(1'b0, 1'b0, pg, 6'(k), {2'b00, img[k]});
		$display("test program unlocked done");
		pg = pg + 9'h001;
		new_img();
		prog(1'b1, pg, 10'h100);
		chk({9'h0, lock_on}, 10'h001);
		for (int k = 0; k < 64; k += 21) issue(1'b0, 1'b0, pg, 6'(k), {2'b00, img[k]});
		$display("test program with prefix done");
		pg = pg + 9'h001;
		new_img();
		img[63] = ~init_v({pg, 6'h3f});
		prog(1'b0, pg, 10'h200);
		for (int k = 0; k < 64; k += 21) begin
			issue(1'b0, 1'b0, pg, 6'(k), {2'b00, init_v({pg, 6'(k)})});
		end
		$display("test locked write without prefix done");
		prog(1'b1, pg, 10'h100);
		for (int k = 0; k < 64; k += 21) issue(1'b0, 1'b0, pg, 6'(k), {2'b00, img[k]});
		chk({9'h0, page_viol}, 10'h000);
		$display("test locked write with prefix done");
		close_out();
	end
endmodule : pfw_ctrl_tb_top

/* pfw_flash_model.sv */
// Purpose: behavioural parallel flash on the far side of the page write controller
// Assumes: 1ns time unit; write cycle and power-up delay shortened by parameter
// Notes:   no chip erase or identification; unloaded page bytes read back unknown
`timescale 1ns/1ps
module pfw_flash_model #(
	parameter int          TMO_NS = 150000,
	parameter int          WC_NS  = 20000,
	parameter int          PWR_NS = 1000,
	parameter int          FLT_NS = 15,
	parameter logic [14:0] LA0    = 15'h0001,
	parameter logic [14:0] LA1    = 15'h0002,
	parameter logic [14:0] LA2    = 15'h0003,
	parameter logic [7:0]  LD0    = 8'h01,
	parameter logic [7:0]  LD1    = 8'h02,
	parameter logic [7:0]  LD2    = 8'h03
) (
	// strobes and address
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [14:0] addr,
	// data
	input  wire logic [7:0]  dq_in,
	output logic      [7:0]  dq_out,
	output logic             dq_en,
	// status for the bench
	output logic             lock_on,
	output logic             page_viol
);
	logic [7:0]  mem [0:32767];
	logic [7:0]  pbuf [0:63];
	logic [63:0] ld_mask;
	logic [14:0] a_lat;
	logic [8:0]  pg;
	logic [7:0]  last_d;
	logic        busy, loading, armed, tog, has_pg;
	int          pm, gen;
	realtime     t_fall;
	wire         wr_s = ce_n | we_n;

	initial begin
		for (int i = 0; i < 32768; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
		{busy, loading, armed, tog, lock_on, page_viol} = '0;
		gen = 0;
	end
	assign dq_en  = !ce_n && !oe_n && we_n;
	// while busy every read is a status read, whatever the address
	assign dq_out = busy ? {~last_d[7], tog, 6'h2a} : mem[addr];
	always @(negedge (ce_n | oe_n)) begin
		if (busy) tog = ~tog;
	end
	// the later falling edge of select and strobe is the fall of their OR
	always @(negedge wr_s) begin
		if (oe_n && !busy && $realtime >= PWR_NS) begin
			a_lat  = addr;
			t_fall = $realtime;
			armed  = 1'b1;
		end
	end
	always @(posedge wr_s) begin
		if (armed && oe_n && $realtime - t_fall >= FLT_NS) load(a_lat, dq_in);
		armed = 1'b0;
	end

	task automatic load(input logic [14:0] a, input logic [7:0] d);
		int g;
		if (!loading) begin
			{loading, has_pg} = 2'b10;
			pm      = 0;
			ld_mask = '0;
		end
		if (pm < 3 && !has_pg && {a, d} == (pm == 0 ? {LA0, LD0} : pm == 1 ? {LA1, LD1} : {LA2, LD2}))
			pm++;
		else begin
			if (has_pg && a[14:6] != pg) page_viol = 1'b1;
			{has_pg, pg, last_d} = {1'b1, a[14:6], d};
			pbuf[a[5:0]]    = d;
			ld_mask[a[5:0]] = 1'b1;
		end
		gen++;
		g = gen;
		fork
			begin
				#(TMO_NS);
				if (g == gen) cycle();
			end
		join_none
	endtask : load

	task automatic cycle();
		logic store;
		loading = 1'b0;
		busy    = 1'b1;
		store   = pm == 3 || !lock_on;
		if (pm == 3) lock_on = 1'b1;
		#(WC_NS);
		if (store && has_pg)
			for (int i = 0; i < 64; i++) mem[{pg, 6'(i)}] = ld_mask[i] ? pbuf[i] : 8'hxx;
		busy = 1'b0;
	endtask : cycle
endmodule : pfw_flash_model

/* pfw_page_ram.sv */
// Purpose: page image buffer, one write port and a registered read port
// Assumes: single clock, no reset on the array
// Notes:   read data appear one cycle after the address
`timescale 1ns/1ps
module pfw_page_ram #(
	parameter int W = 8,
	parameter int D = 64,
	parameter int A = 6
) (
	// clock
	input  wire logic         sys_clk,
	// write side
	input  wire logic         wr_en,
	input  wire logic [A-1:0] wr_addr,
	input  wire logic [W-1:0] wr_data,
	// read side
	input  wire logic [A-1:0] rd_addr,
	output logic      [W-1:0] rd_data
);
	logic [W-1:0] mem [D];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule : pfw_page_ram

/* pfw_pkg.sv */
// Purpose: shared constants and state type for the page flash write controller
// Assumes: sys_clk at 25 MHz; the flash is a 32K x 8 part with a 64-byte page
// Notes:   timing counts are derived here from the printed times
//
// How it works
// - a load is a write strobe low pulse with chip select low, output enable high
// - host loads all 64 bytes of a page for every program
// - each next load starts within 150 us; silence ends the load period
// - page address stays the same at every falling strobe of one load period; the three prefix loads carry the pages of LOCK_ADDR0 to LOCK_ADDR2
// - host opens a program with the three-load prefix only when lock_prefix_en is set
// - host sends prefix loads with the same timing as page loads
package pfw_pkg;
	localparam int CLK_MHZ      = 25;
	localparam int ADDR_W       = 15;
	localparam int PAGE_W       = 9;
	localparam int IDX_W        = 6;
	localparam int DATA_W       = 8;
	localparam int PAGE_BYTES   = 64;
	localparam int PREFIX_LEN   = 3;
	localparam int POLL_BIT     = 7;
	localparam int TOGGLE_BIT   = 6;
	localparam int LOAD_TMO_US  = 150;
	localparam int LOAD_TMO_CYC = LOAD_TMO_US * CLK_MHZ;
	localparam int WC_MS        = 10;
	localparam int WC_CYC       = WC_MS * 1000 * CLK_MHZ;
	localparam int PWRUP_MS     = 5;
	localparam int PWRUP_CYC    = PWRUP_MS * 1000 * CLK_MHZ;
	localparam int GLITCH_NS    = 15;
	// one cycle beyond the filter width, so a slow edge still reads as a pulse
	localparam int WE_LOW_CYC   = (GLITCH_NS * CLK_MHZ + 999) / 1000 + 1;
	localparam int ACC_NS       = 150;
	localparam int ACC_CYC      = (ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_STG     = 3;
	localparam int RD_WAIT      = ACC_CYC + SYNC_STG;
	localparam int CNT_W        = 20;
	localparam int WC_W         = 32;

	typedef enum logic [3:0] {
		PFW_PWR  = 4'h0,
		PFW_IDLE = 4'h1,
		PFW_WSET = 4'h3,
		PFW_WLOW = 4'h2,
		PFW_WHI  = 4'h6,
		PFW_TMO  = 4'h7,
		PFW_PRD  = 4'h5,
		PFW_PGAP = 4'h4,
		PFW_RD   = 4'h9
	} pfw_state_t;
endpackage : pfw_pkg
